// ==== fso_ctrl.sv ====
/*
  Suspend/resume sequencing for array program and erase, and the
  64+1 byte OTP array with its lock byte, inside a serial flash.
  Assumes: link_clk is the host serial clock (mode 0, idle low),
  stopped outside frames; arr_* and rd_addr come from core logic.
*/
// Operation
// - Suspend opcode halts a running program or erase within suspend latency.
// - Accepted suspend sets flag bit 2 for program, bit 6 for erase.
// - After the latency flag bit 7 rises; host then sees device suspended.
// - Too little time left: finish instead, then clear the suspend flag.
// - Suspend state is volatile; flag status resets to 80h.
// - One nesting: erase then program suspended; resumes run program first.
// - Reads of the suspended program page are undefined, others served.
// - Erase suspended: program and read allowed outside the suspended sector.
// - Program to erase-suspended sector ignored, flag bit 4 set, latch kept.
// - Resumed erase does not recheck volatile lock bits.
// - Resume sets busy, clears ready bit; ignored when nothing suspended.
// - Ready bit stays 0 during resumed operation, returns to 1 after.
// - OTP read: opcode, address, dummy in on rise; data out on fall.
// - OTP read address increments, sticks at location 0x40.
// - Chip select high ends OTP read; output stops driving.
// - OTP program ignored without write enable latch, no flags set.
// - OTP program starts only at chip select rise on a byte boundary.
// - At most 65 OTP bytes latched; further bytes discarded.
// - OTP program holds busy, then clears busy and write enable latch.
// - OTP program timeout clears latch and sets program fail flag.
// - Control byte bit 0 locks OTP array; once 0 it stays 0 until reset reloads all ones.
// - Locked OTP: program ignored, latch kept, flag bits 1 and 4 set.
`timescale 1ns/1ps
module fso_ctrl #(
  parameter int OTP_PROG_CYC = fso_pkg::OTP_PROG_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic serial_data_in_line,
  output logic serial_data_out_line,
  output logic serial_data_out_oe,
  input wire logic arr_start,
  input wire logic arr_erase,
  input wire logic [23:0] arr_addr,
  input wire logic [23:0] arr_cycles,
  input wire logic [23:0] rd_addr,
  input wire logic otp_cell_ok,
  output logic wip,
  output logic wel,
  output logic [7:0] flag_status,
  output logic rd_undefined,
  output logic arr_running
);
  if (OTP_PROG_CYC < 2 || OTP_PROG_CYC > 16777215) begin : g_chk
    $error("OTP_PROG_CYC out of range");
  end

  localparam logic [23:0] LAT24 = 24'(fso_pkg::SUSP_LAT_CYC);
  localparam logic [23:0] OTP24 = 24'(OTP_PROG_CYC);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN = 4'b0010,
    ST_HALT = 4'b0100,
    ST_OTP = 4'b1000
  } fso_st_t;

  // Link side, cleared by chip select high
  typedef struct packed {
    logic act;
    logic [15:0] sy1;
    logic [15:0] sy2;
  } fso_lnk_t;

  // Link side frame record, kept after the frame for the core
  typedef struct packed {
    logic [9:0] cnt;
    logic [7:0] sh;
    logic [7:0] op;
    logic [23:0] addr;
    logic [64:0][7:0] dat;
    logic [64:0] msk;
  } fso_frm_t;

  typedef struct packed {
    fso_st_t st;
    logic cs1;
    logic cs2;
    logic cs3;
    logic wip;
    logic wel;
    logic [7:0] fsr;
    logic erase;
    logic [23:0] addr;
    logic [23:0] tmr;
    logic [fso_pkg::LAT_W-1:0] lat;
    logic esv;
    logic [23:0] erem;
    logic [23:0] eaddr;
    logic psv;
    logic [23:0] prem;
    logic [23:0] paddr;
    logic [64:0][7:0] otp;
    logic [64:0][7:0] pdat;
    logic [64:0] pmsk;
    logic rd_undef;
  } fso_core_t;

  fso_lnk_t lk_q, lk_d;
  fso_frm_t fr_q, fr_d;
  fso_core_t c_q, c_d;
  logic [9:0] base;
  logic [6:0] nbyte;
  logic [6:0] didx;
  logic [7:0] pidx;
  logic [9:0] rs;
  logic [9:0] ro;
  logic [9:0] ix;
  logic [7:0] stat;
  logic obit;
  logic oen;
  logic fend;
  logic whole;
  logic susp_cmd;
  logic res_cmd;
  logic wren_cmd;
  logic otp_cmd;
  logic [2:0] sbit;

  // Frame capture on the rising link edge
  always_comb begin
    fr_d = fr_q;
    base = lk_q.act ? fr_q.cnt : 10'h000;
    nbyte = base[9:3];
    didx = nbyte - fso_pkg::ADDR_BYTES;
    pidx = {1'b0, fr_q.addr[6:0]} + {1'b0, didx};
    if (!lk_q.act) begin
      fr_d.msk = '0;
    end
    fr_d.sh = {fr_q.sh[6:0], serial_data_in_line};
    if (base != fso_pkg::CNT_MAX) begin
      fr_d.cnt = base + 10'h001;
    end
    if (base[2:0] == 3'h7) begin
      if (nbyte == 7'h00) begin
        fr_d.op = fr_d.sh;
      end else if (nbyte < fso_pkg::ADDR_BYTES) begin
        fr_d.addr = {fr_q.addr[15:0], fr_d.sh};
      end else if (fr_q.op == fso_pkg::OP_OTP_PROG && didx <= fso_pkg::OTP_LAST
                   && pidx <= fso_pkg::OTP_LAST8) begin
        // No rollover: bytes past location 64 are dropped
        fr_d.dat[pidx[6:0]] = fr_d.sh;
        fr_d.msk[pidx[6:0]] = 1'b1;
      end
    end
  end

  // Status bytes cross into the link domain as two-flop levels
  always_comb begin
    lk_d = lk_q;
    lk_d.act = 1'b1;
    lk_d.sy1 = {6'h00, c_q.wel, c_q.wip, c_q.fsr};
    lk_d.sy2 = lk_q.sy1;
  end

  // Chip select high clears the frame state; the record stays
  always_ff @(posedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  always_ff @(posedge link_clk) begin
    fr_q <= fr_d;
  end

  // Output bit selection; OTP array is read quasi-static
  always_comb begin
    rs = fr_q.cnt - fso_pkg::CMD_BITS;
    ro = fr_q.cnt - fso_pkg::OTP_RD_BITS;
    ix = {3'h0, fr_q.addr[6:0]} + {3'h0, ro[9:3]};
    if (ix > fso_pkg::OTP_LAST10) begin
      ix = fso_pkg::OTP_LAST10;
    end
    stat = (fr_q.op == fso_pkg::OP_RD_SR) ? lk_q.sy2[15:8] : lk_q.sy2[7:0];
    oen = 1'b0;
    obit = 1'b0;
    if (lk_q.act && fr_q.cnt >= fso_pkg::CMD_BITS) begin
      if (fr_q.op == fso_pkg::OP_RD_SR || fr_q.op == fso_pkg::OP_RD_FSR) begin
        oen = 1'b1;
        obit = stat[~rs[2:0]];
      end else if (fr_q.op == fso_pkg::OP_OTP_RD && fr_q.cnt >= fso_pkg::OTP_RD_BITS) begin
        oen = 1'b1;
        obit = c_q.otp[ix[6:0]][~ro[2:0]];
      end
    end
  end

  // Data leaves on the falling edge; chip select high releases it
  always_ff @(negedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      serial_data_out_line <= 1'b0;
      serial_data_out_oe <= 1'b0;
    end else begin
      serial_data_out_line <= obit;
      serial_data_out_oe <= oen;
    end
  end

  // Frame end seen in core domain; record is stable once link is quiet
  assign fend = c_q.cs2 & ~c_q.cs3;
  assign whole = fr_q.cnt[2:0] == 3'h0;
  assign susp_cmd = fend && fr_q.op == fso_pkg::OP_SUSP && fr_q.cnt == fso_pkg::CMD_BITS;
  assign res_cmd = fend && fr_q.op == fso_pkg::OP_RESUME && fr_q.cnt == fso_pkg::CMD_BITS;
  assign wren_cmd = fend && fr_q.op == fso_pkg::OP_WREN && fr_q.cnt == fso_pkg::CMD_BITS;
  assign otp_cmd = fend && fr_q.op == fso_pkg::OP_OTP_PROG && whole
                   && fr_q.cnt >= fso_pkg::OTP_PRG_MIN;
  assign sbit = c_q.erase ? 3'(fso_pkg::FB_ESUSP) : 3'(fso_pkg::FB_PSUSP);

  // Core sequencer
  always_comb begin
    c_d = c_q;
    c_d.cs1 = cs_n;
    c_d.cs2 = c_q.cs1;
    c_d.cs3 = c_q.cs2;
    // Suspended page or sector reads back undefined
    c_d.rd_undef = (c_q.psv && rd_addr[23:8] == c_q.paddr[23:8])
                   || (c_q.esv && rd_addr[23:16] == c_q.eaddr[23:16]);
    if (wren_cmd) begin
      c_d.wel = 1'b1;
    end
    unique case (c_q.st)
      ST_IDLE: begin
        // Suspend here has nothing to act on and is dropped
        if (res_cmd && c_q.psv) begin
          c_d.psv = 1'b0;
          c_d.fsr[fso_pkg::FB_PSUSP] = 1'b0;
          c_d.erase = 1'b0;
          c_d.addr = c_q.paddr;
          c_d.tmr = c_q.prem;
          c_d.wip = 1'b1;
          c_d.fsr[fso_pkg::FB_READY] = 1'b0;
          c_d.st = ST_RUN;
        end else if (res_cmd && c_q.esv) begin
          // Lock bits changed meanwhile are not looked at again
          c_d.esv = 1'b0;
          c_d.fsr[fso_pkg::FB_ESUSP] = 1'b0;
          c_d.erase = 1'b1;
          c_d.addr = c_q.eaddr;
          c_d.tmr = c_q.erem;
          c_d.wip = 1'b1;
          c_d.fsr[fso_pkg::FB_READY] = 1'b0;
          c_d.st = ST_RUN;
        end else if (otp_cmd && c_q.wel) begin
          if (!c_q.otp[64][fso_pkg::LOCK_BIT]) begin
            c_d.fsr[fso_pkg::FB_PROT] = 1'b1;
            c_d.fsr[fso_pkg::FB_PFAIL] = 1'b1;
          end else begin
            // Copy the record now: the host may poll during the write
            c_d.pdat = fr_q.dat;
            c_d.pmsk = fr_q.msk;
            c_d.tmr = OTP24;
            c_d.wip = 1'b1;
            c_d.fsr[fso_pkg::FB_READY] = 1'b0;
            c_d.st = ST_OTP;
          end
        end else if (arr_start && !c_q.psv) begin
          if (!arr_erase && c_q.esv && arr_addr[23:16] == c_q.eaddr[23:16]) begin
            c_d.fsr[fso_pkg::FB_PFAIL] = 1'b1;
          end else if (!arr_erase || !c_q.esv) begin
            c_d.erase = arr_erase;
            c_d.addr = arr_addr;
            c_d.tmr = (arr_cycles == 24'h000000) ? 24'h000001 : arr_cycles;
            c_d.wip = 1'b1;
            c_d.fsr[fso_pkg::FB_READY] = 1'b0;
            c_d.st = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        c_d.tmr = c_q.tmr - 24'h000001;
        if (susp_cmd && !c_q.fsr[sbit]) begin
          c_d.fsr[sbit] = 1'b1;
          // Short remainder: run on to the end instead
          if (c_q.tmr >= LAT24) begin
            c_d.tmr = c_q.tmr;
            c_d.lat = fso_pkg::LAT_W'(fso_pkg::SUSP_LAT_CYC);
            c_d.st = ST_HALT;
          end
        end
        if (c_q.tmr <= 24'h000001) begin
          c_d.fsr[sbit] = 1'b0;
          c_d.fsr[fso_pkg::FB_READY] = 1'b1;
          c_d.wip = 1'b0;
          c_d.st = ST_IDLE;
        end
      end
      ST_HALT: begin
        c_d.lat = c_q.lat - fso_pkg::LAT_W'(1);
        if (c_q.lat <= fso_pkg::LAT_W'(1)) begin
          c_d.fsr[fso_pkg::FB_READY] = 1'b1;
          c_d.wip = 1'b0;
          c_d.st = ST_IDLE;
          if (c_q.erase) begin
            c_d.esv = 1'b1;
            c_d.erem = c_q.tmr;
            c_d.eaddr = c_q.addr;
          end else begin
            c_d.psv = 1'b1;
            c_d.prem = c_q.tmr;
            c_d.paddr = c_q.addr;
          end
        end
      end
      ST_OTP: begin
        c_d.tmr = c_q.tmr - 24'h000001;
        if (c_q.tmr <= 24'h000001) begin
          c_d.wip = 1'b0;
          c_d.wel = 1'b0;
          c_d.fsr[fso_pkg::FB_READY] = 1'b1;
          c_d.st = ST_IDLE;
          if (otp_cell_ok) begin
            // Cells only go 1 to 0, so programming cannot reopen the lock
            for (int i = 0; i < 65; i++) begin
              if (c_q.pmsk[i]) begin
                c_d.otp[i] = c_q.otp[i] & c_q.pdat[i];
              end
            end
          end else begin
            c_d.fsr[fso_pkg::FB_PFAIL] = 1'b1;
          end
        end
      end
      default: begin
        c_d.st = ST_IDLE;
      end
    endcase
  end

  // Reset models power-up: suspend state lost, flags at 80h
  always_ff @(posedge core_clk) begin
    if (srst) begin
      c_q <= '0;
      c_q.st <= ST_IDLE;
      c_q.cs1 <= 1'b1;
      c_q.cs2 <= 1'b1;
      c_q.cs3 <= 1'b1;
      c_q.fsr <= fso_pkg::FSR_RST;
      c_q.otp <= '1;
    end else begin
      c_q <= c_d;
    end
  end

  assign wip = c_q.wip;
  assign wel = c_q.wel;
  assign flag_status = c_q.fsr;
  assign rd_undefined = c_q.rd_undef;
  assign arr_running = c_q.st[1];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  a_susp_erase_flag: assert property ((c_q.st == ST_RUN && susp_cmd && c_q.erase && c_q.tmr > 24'h000001) |=> c_q.fsr[6])
    else $error("erase suspend flag not set");
  a_halt_end_ready: assert property ((c_q.st == ST_HALT && c_q.lat == 1) |=> c_q.fsr[7] && !c_q.wip
    && c_q.st == ST_IDLE)
    else $error("halt did not end in suspended state");
  a_halt_holds_busy: assert property ((c_q.st == ST_HALT) |-> !c_q.fsr[7] && c_q.wip)
    else $error("ready shown before suspend latency");
  a_short_finish: assert property ((c_q.st == ST_RUN && susp_cmd && c_q.tmr < LAT24) |=>
    c_q.st != ST_HALT)
    else $error("short remainder was suspended");
  a_resume_start: assert property ((c_q.st == ST_IDLE && res_cmd && (c_q.psv || c_q.esv)) |=>
    c_q.wip && !c_q.fsr[7] && c_q.st == ST_RUN)
    else $error("resume did not restart");
  a_resume_ignored: assert property ((c_q.st == ST_IDLE && res_cmd && !c_q.psv && !c_q.esv
    && !arr_start) |=> $stable(c_q.fsr) && !c_q.wip)
    else $error("resume acted with nothing suspended");
  a_run_not_ready: assert property ((c_q.st == ST_RUN) |-> !c_q.fsr[7])
    else $error("ready bit set during operation");
  a_nest_order: assert property ((c_q.st == ST_IDLE && res_cmd && c_q.psv && c_q.esv) |=>
    !c_q.erase && c_q.esv)
    else $error("nested resume order wrong");
  a_sector_block: assert property ((c_q.st == ST_IDLE && arr_start && !arr_erase && c_q.esv
    && !c_q.psv && !res_cmd && !otp_cmd && arr_addr[23:16] == c_q.eaddr[23:16]) |=>
    c_q.fsr[4] && c_q.st == ST_IDLE)
    else $error("program into suspended sector accepted");
  a_otp_no_wel: assert property ((c_q.st == ST_IDLE && otp_cmd && !c_q.wel && !res_cmd
    && !arr_start) |=> c_q.st == ST_IDLE && $stable(c_q.fsr))
    else $error("otp program ran without latch");
  a_otp_locked: assert property ((c_q.st == ST_IDLE && otp_cmd && c_q.wel && !res_cmd
    && !c_q.otp[64][0]) |=> c_q.fsr[1] && c_q.fsr[4] && c_q.wel)
    else $error("locked otp not refused");
  a_otp_done: assert property ((c_q.st == ST_OTP && c_q.tmr == 1) |=> !c_q.wip && !c_q.wel)
    else $error("otp end did not clear busy and latch");
  a_lock_sticky: assert property (!c_q.otp[64][0] |=> !c_q.otp[64][0])
    else $error("otp lock reopened");
endmodule

// ==== fso_pkg.sv ====
/*
  Constants for the suspend/resume and OTP sequencer: opcodes,
  status bit positions, reset values and timing counts.
  Assumes a 40 MHz core clock; nothing else.
*/
package fso_pkg;
  // Core clock period and the two self-timed durations
  localparam int CLK_PERIOD_NS = 25;
  localparam int SUSP_LAT_NS = 30000;
  // Longest time: rounds down
  localparam int SUSP_LAT_CYC = SUSP_LAT_NS / CLK_PERIOD_NS;
  localparam int LAT_W = $clog2(SUSP_LAT_CYC + 1);
  localparam int OTP_PROG_US = 2000;
  localparam int OTP_PROG_CYC = (OTP_PROG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Command codes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_RD_SR = 8'h05;
  localparam logic [7:0] OP_RD_FSR = 8'h70;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_OTP_RD = 8'h4b;
  localparam logic [7:0] OP_OTP_PROG = 8'h42;

  // Flag status bits and reset value
  localparam int FB_READY = 7;
  localparam int FB_ESUSP = 6;
  localparam int FB_PFAIL = 4;
  localparam int FB_PSUSP = 2;
  localparam int FB_PROT = 1;
  localparam logic [7:0] FSR_RST = 8'h80;

  // Frame layout in link clock bits
  localparam logic [9:0] CMD_BITS = 10'h008;
  localparam logic [9:0] OTP_RD_BITS = 10'h028;
  localparam logic [9:0] OTP_PRG_MIN = 10'h028;
  localparam logic [9:0] CNT_MAX = 10'h3ff;
  localparam logic [6:0] ADDR_BYTES = 7'h04;
  localparam logic [6:0] OTP_LAST = 7'h40;
  localparam logic [7:0] OTP_LAST8 = 8'h40;
  localparam logic [9:0] OTP_LAST10 = 10'h040;
  localparam int LOCK_BIT = 0;
endpackage

// ==== fso_host_model.sv ====
/*
  Host side of the serial link: sends opcode, address and data bytes
  and reads reply bytes. Assumes the device samples on rising link_clk
  and shifts out on falling link_clk (mode 0).
*/
`timescale 1ns/1ps
module fso_host_model (
  output logic link_clk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  logic [7:0] rx[$];
  // Clock idles low and only runs inside a frame
  initial begin
    link_clk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // Send bytes MSB first minus trim bits, then read nrd bytes
  task automatic frame(input logic [7:0] tx[$], input int trim, input int nrd);
    logic [7:0] b;
    int n;
    rx = {};
    b = 8'h00;
    n = tx.size() * 8 - trim;
    cs_n = 1'b0;
    #3;
    for (int i = 0; i < n; i++) begin
      sdi = tx[i / 8][7 - i % 8];
      #3 link_clk = 1'b1;
      #3 link_clk = 1'b0;
    end
    for (int i = 0; i < nrd * 8; i++) begin
      // Input line carries no meaning now, so keep it moving
      sdi = ~sdi;
      #3 link_clk = 1'b1;
      b = {b[6:0], sdo};
      if (i % 8 == 7) rx.push_back(b);
      #3 link_clk = 1'b0;
    end
    #3 cs_n = 1'b1;
    sdi = ~sdi;
    // Quiet gap so the core sees the frame end before the next one
    #200;
  endtask
endmodule

// ==== tb_top.sv ====
/*
  Self-checking bench for fso_ctrl: serial frames through the host
  model, array requests in the core domain, status checks.
  Assumes a shortened OTP duration and the fixed suspend latency.
*/
`timescale 1ns/1ps
module tb_top;
  logic core_clk, srst, link_clk, cs_n, sdi, sdo, sdo_oe;
  logic arr_start, arr_erase, otp_cell_ok, wip, wel, rd_undef, arr_running;
  logic [23:0] arr_addr, arr_cycles, rd_addr;
  logic [7:0] flag_status;
  logic [7:0] exp_q[4];
  int miscompares = 0;
  int checks_done = 0;

  fso_ctrl #(.OTP_PROG_CYC(20)) i_fso_ctrl (.core_clk(core_clk), .srst(srst), .link_clk(link_clk),
    .cs_n(cs_n), .serial_data_in_line(sdi), .serial_data_out_line(sdo), .serial_data_out_oe(sdo_oe),
    .arr_start(arr_start), .arr_erase(arr_erase), .arr_addr(arr_addr), .arr_cycles(arr_cycles),
    .rd_addr(rd_addr), .otp_cell_ok(otp_cell_ok), .wip(wip), .wel(wel), .flag_status(flag_status),
    .rd_undefined(rd_undef), .arr_running(arr_running));
  fso_host_model i_fso_host_model (.link_clk(link_clk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

  // 40 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic test_done;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run is about 15k core cycles; give it well over twice that
  initial begin
    #1000000;
    miscompares++;
    $display("wrong value at %0t: watchdog expired", $time);
    test_done();
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic do_reset;
    @(negedge core_clk);
    srst = 1'b1;
    cyc(8);
    srst = 1'b0;
  endtask
  task automatic cmd(input logic [7:0] op);
    i_fso_host_model.frame('{op}, 0, 0);
  endtask
  // One-cycle array request, inputs changed on the falling edge
  task automatic arr(input logic er, input logic [23:0] a, input logic [23:0] n);
    @(negedge core_clk);
    arr_start = 1'b1;
    arr_erase = er;
    arr_addr = a;
    arr_cycles = n;
    @(negedge core_clk);
    arr_start = 1'b0;
  endtask
  // Bounded wait for the ready flag
  task automatic wait_rdy(input int lim);
    int k;
    k = 0;
    while (flag_status[7] !== 1'b1 && k < lim) begin
      cyc(1);
      k++;
    end
    chk({7'h00, flag_status[7]}, 8'h01, "ready wait");
  endtask
  task automatic rd(input logic [23:0] a, input logic e);
    cyc(1);
    rd_addr = a;
    cyc(2);
    chk({7'h00, rd_undef}, {7'h00, e}, "read region");
  endtask

  initial begin
    srst = 1'b1;
    arr_start = 1'b0;
    arr_erase = 1'b0;
    arr_addr = 24'h000000;
    arr_cycles = 24'h000000;
    rd_addr = 24'h000000;
    otp_cell_ok = 1'b1;
    do_reset();
    cyc(1);
    chk(flag_status, 8'h80, "reset flags");
    chk({6'h00, wip, wel}, 8'h00, "reset busy");
    // OTP program refusals, program, timeout, lock and read back
    i_fso_host_model.frame('{8'h42, 8'h00, 8'h00, 8'h3e, 8'h00}, 0, 0);
    chk({7'h00, wip}, 8'h00, "otp no wel");
    chk(flag_status, 8'h80, "otp no wel flags");
    cmd(8'h06);
    i_fso_host_model.frame('{8'h42, 8'h00, 8'h00, 8'h3e, 8'h00, 8'h00}, 3, 0);
    i_fso_host_model.frame('{8'h05}, 0, 1);
    chk(i_fso_host_model.rx[0], 8'h02, "partial frame");
    chk(flag_status, 8'h80, "partial frame flags");
    i_fso_host_model.frame('{8'h42, 8'h00, 8'h00, 8'h3e, 8'h12}, 0, 0);
    chk({6'h00, wip, wel}, 8'h03, "otp busy");
    cyc(30);
    chk({6'h00, wip, wel}, 8'h00, "otp done");
    cmd(8'h06);
    cyc(1);
    otp_cell_ok = 1'b0;
    i_fso_host_model.frame('{8'h42, 8'h00, 8'h00, 8'h3f, 8'h00}, 0, 0);
    cyc(30);
    chk(flag_status, 8'h90, "otp timeout");
    chk({7'h00, wel}, 8'h00, "otp timeout wel");
    otp_cell_ok = 1'b1;
    cmd(8'h06);
    i_fso_host_model.frame('{8'h42, 8'h00, 8'h00, 8'h3f, 8'h34, 8'hfe, 8'h00}, 0, 0);
    cyc(30);
    i_fso_host_model.frame('{8'h4b, 8'h00, 8'h00, 8'h3e, 8'h00}, 0, 4);
    exp_q = '{8'h12, 8'h34, 8'hfe, 8'hfe};
    foreach (exp_q[i]) chk(i_fso_host_model.rx[i], exp_q[i], "otp read");
    chk({7'h00, sdo_oe}, 8'h00, "read end oe");
    cmd(8'h06);
    i_fso_host_model.frame('{8'h42, 8'h00, 8'h00, 8'h00, 8'h00}, 0, 0);
    cyc(30);
    chk({6'h00, wip, wel}, 8'h01, "locked wel");
    chk(flag_status, 8'h92, "locked flags");
    $display("test otp done");
    // Second reset in mid-run clears flags and latch
    do_reset();
    cyc(1);
    chk({wel, flag_status[6:0]}, 8'h00, "second reset");
    cmd(8'h75);
    chk(flag_status, 8'h80, "idle suspend");
    cmd(8'h7a);
    chk({7'h00, wip}, 8'h00, "idle resume");
    // Erase, suspend, nested program, two resumes
    arr(1'b1, 24'h050000, 24'd6000);
    cyc(1);
    chk({6'h00, wip, arr_running}, 8'h03, "erase start");
    cyc(100);
    cmd(8'h75);
    chk(flag_status, 8'h40, "erase suspending");
    wait_rdy(1400);
    chk({7'h00, wip}, 8'h00, "erase halted");
    i_fso_host_model.frame('{8'h70}, 0, 1);
    chk(i_fso_host_model.rx[0], 8'hc0, "serial flags");
    rd(24'h051234, 1'b1);
    rd(24'h060000, 1'b0);
    arr(1'b0, 24'h050100, 24'd100);
    cyc(1);
    chk({arr_running, flag_status[6:0]}, 8'h50, "prog in sector");
    arr(1'b0, 24'h070200, 24'd4000);
    cyc(1);
    chk(flag_status, 8'h50, "nested prog");
    cyc(100);
    cmd(8'h75);
    wait_rdy(1400);
    chk(flag_status, 8'hd4, "both suspended");
    rd(24'h0702aa, 1'b1);
    rd(24'h070300, 1'b0);
    cmd(8'h7a);
    chk({5'h00, wip, flag_status[7:6]}, 8'h05, "first resume");
    wait_rdy(4200);
    chk({5'h00, wip, arr_running, flag_status[6]}, 8'h01, "prog finished");
    cmd(8'h7a);
    chk({6'h00, wip, flag_status[7]}, 8'h02, "second resume");
    wait_rdy(6200);
    chk(flag_status, 8'h90, "erase finished");
    $display("test nesting done");
    // Too little time left: the operation completes instead
    arr(1'b0, 24'h080000, 24'd1300);
    cyc(300);
    cmd(8'h75);
    chk({6'h00, arr_running, flag_status[2]}, 8'h03, "late suspend");
    wait_rdy(1200);
    chk({wip, flag_status[6:0]}, 8'h10, "late suspend done");
    $display("test late suspend done");
    test_done();
  end
endmodule
